// *** dsp_load_instruction_unit.v ***
`timescale 1ns/1ps
`include "load_unit_map.vh"
// executes the load group: page, product high, status, factor, factor-accumulate
module dsp_load_instruction_unit (
  input wire ref_clk, // core clock, 200 MHz
  input wire reset_n, // async reset, active low
  input wire instr_valid, // instruction word offered
  input wire [15:0] instr_word, // instruction word
  output wire instr_ready, // unit idle, takes a word
  input wire [7:0] repeat_n, // repeat_prefix count n, zero means single
  input wire operand_external, // operand in external memory
  input wire code_external, // code in external memory
  input wire same_single_port_ram_block, // operand and code in one single_port_ram block
  input wire [3:0] data_wait, // external operand wait states d
  input wire [3:0] code_wait, // external code wait states p
  output wire [15:0] mem_addr, // data memory address
  output wire mem_rd, // data memory read strobe
  input wire [15:0] mem_rdata, // data memory word, same cycle
  input wire [15:0] aux_reg_value, // selected auxiliary register contents
  output wire aux_update_strobe, // indirect access made, update pointer
  output wire [2:0] aux_update_code, // indirect update option
  input wire irq_mask_write, // other logic writes global_irq_mask
  input wire irq_mask_value, // value for that write
  output reg instr_done, // pulse in the cycle after the instruction's last cycle
  output reg illegal_op, // pulse when word is not in this group
  output wire [15:0] status_word_zero, // composed status word zero
  output wire [15:0] status_word_one, // composed status word one
  output reg [31:0] product_register, // product register
  output reg [15:0] multiplicand_register, // multiplicand register
  output reg [31:0] accumulator // accumulator
);
  localparam S_IDLE = 1'b0; // waiting for a word
  localparam S_RUN = 1'b1; // executing iterations

  // status fields
  reg [2:0] current_aux_pointer; // active aux register
  reg [2:0] aux_pointer_buffer; // previous pointer
  reg sum_out_of_range_flag; // overflow flag
  reg saturate_on_range_enable; // saturate on overflow
  reg global_irq_mask; // interrupt mask
  reg [8:0] page_pointer_field; // data page
  reg ram_block_config_bit; // ram block config
  reg bit_test_result_flag; // test/control flag
  reg sign_extension_enable; // sign extension mode
  reg carry; // carry flag
  reg external_flag_pin_bit; // external flag
  reg [1:0] product_shift_mode; // product shift

  // latched instruction
  reg state; // control state
  reg [2:0] op_class; // decoded class
  reg [15:0] op_word; // instruction word
  reg [8:0] iter_left; // iterations still to run
  reg [13:0] next_budget; // cycle budget for a new word
  reg [2:0] next_class; // class of the offered word

  wire accept; // word taken this cycle
  wire iter_now; // an iteration runs this cycle
  wire timer_busy; // budget running
  wire timer_expire; // budget ends this cycle
  wire op_indirect; // latched word uses indirect form
  wire [15:0] load_data; // word being loaded
  wire [31:0] shifted_prod; // product after shift mode
  wire [32:0] acc_sum; // accumulator plus product with carry out
  wire acc_overflow; // signed overflow of that sum
  wire [13:0] rep_now; // repeat count, zero read as one
  // composed status words are wires; only the fields are stored

  // decode the upper opcode bits into a class
  function [2:0] decode_class;
    input [15:0] w;
    begin
      case (w[15:8])
        `OP_LOAD_PAGE: decode_class = `CL_PAGE;
        `OP_LOAD_PROD_HIGH: decode_class = `CL_PROD_HIGH;
        `OP_LOAD_STATUS_0: decode_class = `CL_STATUS;
        `OP_LOAD_STATUS_1: decode_class = `CL_STATUS;
        `OP_LOAD_FACTOR: decode_class = `CL_FACTOR;
        `OP_LOAD_FACTOR_ACC: decode_class = `CL_FACTOR_ACC;
        default: begin
          // short immediate page load lives on seven opcode bits
          if (w[15:9] == `OP_LOAD_PAGE_IMM)
            decode_class = `CL_PAGE_IMM;
          else
            decode_class = `CL_NONE;
        end
      endcase
    end
  endfunction

  // product shift per product_shift_mode
  function [31:0] shift_product;
    input [31:0] p;
    input [1:0] mode;
    begin
      // mode three shifts right six, keeping the sign
      case (mode)
        `PM_NONE: shift_product = p;
        `PM_LEFT1: shift_product = {p[30:0], 1'b0};
        `PM_LEFT4: shift_product = {p[27:0], 4'h0};
        default: shift_product = {{6{p[31]}}, p[31:6]}; // arithmetic right six
      endcase
    end
  endfunction

  // whole-instruction cycle budget
  always @* begin
    next_class = decode_class(instr_word);
    // two-cycle loads pay base twice per iteration
    // padding cycles come after the iterations, not between them
    if (next_class == `CL_PAGE || next_class == `CL_PAGE_IMM || next_class == `CL_STATUS)
      next_budget = `CYC_TWO * rep_now;
    else
      next_budget = `CYC_ONE * rep_now;
    // immediate page load reads no operand, so no operand waits
    if (operand_external && next_class != `CL_PAGE_IMM)
      next_budget = next_budget + rep_now * {10'h000, data_wait};
    if (code_external)
      next_budget = next_budget + {10'h000, code_wait};
    // external code with external operand costs one more cycle
    if (code_external && operand_external && next_class != `CL_PAGE_IMM)
      next_budget = next_budget + `CYC_ONE;
    // operand and code fighting for one single-port block
    if (same_single_port_ram_block && !operand_external && !code_external
        && next_class != `CL_PAGE_IMM)
      next_budget = next_budget + `CYC_ONE;
  end

  // repeat count as a 14-bit multiplier, zero meaning one pass
  function [13:0] rep_count;
    input [7:0] n;
    begin
      rep_count = (n == 8'h00) ? `CYC_ONE : {6'h00, n};
    end
  endfunction

  // one pass when no repeat prefix is given
  assign rep_now = rep_count(repeat_n);

  assign instr_ready = (state == S_IDLE);
  // a refused word leaves the unit idle
  assign accept = instr_ready && instr_valid && (next_class != `CL_NONE);
  assign iter_now = (state == S_RUN) && (iter_left != 9'h000);
  // the immediate page form reuses bit seven as data
  assign op_indirect = op_word[`F_INDIRECT] && (op_class != `CL_PAGE_IMM);

  // direct form joins page pointer with offset; indirect uses aux register
  assign mem_addr = op_indirect ? aux_reg_value
                                : {page_pointer_field, op_word[`F_OFFSET_HI:0]};
  // the immediate form never reads memory
  assign mem_rd = iter_now && (op_class != `CL_PAGE_IMM);
  // immediate page load takes its nine bits from the word itself
  assign load_data = (op_class == `CL_PAGE_IMM) ? {7'h00, op_word[`SW_DP_HI:0]} : mem_rdata;

  // indirect forms hand the update option to the aux register unit
  assign aux_update_strobe = iter_now && op_indirect;
  // the code only means something while the strobe is high
  assign aux_update_code = op_word[`F_UPD_HI:`F_UPD_LO];

  // reserved positions always read as ones
  assign status_word_zero = {current_aux_pointer, sum_out_of_range_flag,
                             saturate_on_range_enable, 1'b0, global_irq_mask,
                             page_pointer_field} | `ST0_RSVD;
  assign status_word_one = {aux_pointer_buffer, ram_block_config_bit,
                            bit_test_result_flag, sign_extension_enable, carry,
                            4'h0, external_flag_pin_bit, 2'h0,
                            product_shift_mode} | `ST1_RSVD;

  assign shifted_prod = shift_product(product_register, product_shift_mode);
  assign acc_sum = {1'b0, accumulator} + {1'b0, shifted_prod};
  // signed overflow: equal input signs, different result sign
  assign acc_overflow = (accumulator[31] == shifted_prod[31])
                        && (acc_sum[31] != accumulator[31]);

  // the timer owns the length; the sequencer only counts iterations
  cycle_timer i_cycle_timer (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .start(accept),
    .budget(next_budget),
    .busy(timer_busy),
    .expire(timer_expire)
  );

  // sequencing: latch word, run iterations, finish on budget end
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= S_IDLE;
      op_class <= `CL_NONE;
      op_word <= 16'h0000;
      iter_left <= 9'h000;
      instr_done <= 1'b0;
      illegal_op <= 1'b0;
    end else begin
      instr_done <= 1'b0;
      // a word outside this group is refused with a pulse
      illegal_op <= instr_ready && instr_valid && (next_class == `CL_NONE);
      case (state)
        S_IDLE: begin
          if (accept) begin
            // every qualifier is captured at the take edge
            state <= S_RUN;
            op_class <= next_class;
            op_word <= instr_word;
            iter_left <= rep_now[8:0];
          end
        end
        S_RUN: begin
          // iterations run one per cycle, the budget pads the rest
          if (iter_now)
            iter_left <= iter_left - 9'h001;
          // done is registered, so it shows one cycle after the last
          if (timer_expire) begin
            instr_done <= 1'b1;
            state <= S_IDLE;
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

  // data registers touched by the loads
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      product_register <= 32'h00000000;
      multiplicand_register <= 16'h0000;
      accumulator <= 32'h00000000;
    end else if (iter_now) begin
      case (op_class)
        // the low half is never named here, so it keeps its value
        `CL_PROD_HIGH: product_register[31:16] <= load_data;
        `CL_FACTOR: multiplicand_register <= load_data;
        `CL_FACTOR_ACC: begin
          multiplicand_register <= load_data;
          // saturate only when the overflow mode asks for it
          if (acc_overflow && saturate_on_range_enable)
            accumulator <= accumulator[31] ? `ACC_MAX_NEG : `ACC_MAX_POS;
          else
            accumulator <= acc_sum[31:0];
        end
        default: accumulator <= accumulator; // other loads leave it
      endcase
    end
  end

  // status fields; global_irq_mask only moves on its own write port
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      current_aux_pointer <= 3'h0;
      aux_pointer_buffer <= 3'h0;
      sum_out_of_range_flag <= 1'b0;
      saturate_on_range_enable <= 1'b0;
      // mask, sign extension and external flag wake up set
      global_irq_mask <= `RST_IRQ_MASK;
      page_pointer_field <= 9'h000;
      ram_block_config_bit <= 1'b0;
      bit_test_result_flag <= 1'b0;
      sign_extension_enable <= `RST_SIGN_EXT;
      carry <= 1'b0;
      external_flag_pin_bit <= `RST_EXT_FLAG;
      product_shift_mode <= 2'h0;
    end else begin
      // the mask moves only on its own port, never on a status load
      if (irq_mask_write)
        global_irq_mask <= irq_mask_value;
      if (iter_now) begin
        // next pointer operand applies to all but the status load
        if (op_indirect && op_word[`F_NEXT_EN] && op_class != `CL_STATUS)
          current_aux_pointer <= op_word[`F_NEXT_HI:0];
        case (op_class)
          `CL_PAGE, `CL_PAGE_IMM: page_pointer_field <= load_data[`SW_DP_HI:0];
          `CL_FACTOR_ACC: begin
            // carry follows every add, set or cleared
            carry <= acc_sum[32];
            // overflow is sticky, never cleared by this add
            if (acc_overflow)
              sum_out_of_range_flag <= 1'b1;
          end
          `CL_STATUS: begin
            if (!op_word[`F_STATUS_SEL]) begin
              // word zero: new pointer, buffer untouched
              // the mask and the reserved bit are skipped on purpose
              current_aux_pointer <= load_data[`SW_PTR_HI:`SW_PTR_LO];
              sum_out_of_range_flag <= load_data[`SW0_OV];
              saturate_on_range_enable <= load_data[`SW0_OVM];
              page_pointer_field <= load_data[`SW_DP_HI:0];
            end else begin
              // word one: buffer and pointer take the same bits
              // reserved positions are not stored, so writes to them vanish
              aux_pointer_buffer <= load_data[`SW_PTR_HI:`SW_PTR_LO];
              current_aux_pointer <= load_data[`SW_PTR_HI:`SW_PTR_LO];
              ram_block_config_bit <= load_data[`SW1_CNF];
              bit_test_result_flag <= load_data[`SW1_TC];
              sign_extension_enable <= load_data[`SW1_SXM];
              carry <= load_data[`SW1_C];
              external_flag_pin_bit <= load_data[`SW1_XF];
              product_shift_mode <= load_data[`SW1_PM_HI:0];
            end
          end
          default: carry <= carry; // other loads leave flags
        endcase
      end
    end
  end
endmodule

// *** load_unit_map.vh ***
// How it works
// - direct address is page_pointer_field then 7-bit offset
// - page pointer load takes 2 cycles, 2n repeated
// - same single_port_ram block adds one cycle, except immediate page load
// - bits 15:8 pick op, bit 7 picks indirect; immediate page load uses bits 15:9 and bit 7 as data
// - product high load fills bits 31:16 only
// - product high load 1 cycle, n repeated, plus waits
// - opcode bit 8 selects status word zero or one
// - status load updates the listed status fields
// - status load never touches global_irq_mask
// - status word zero load leaves aux_pointer_buffer alone
// - status word one load copies buffer into pointer
// - indirect status load ignores next pointer operand
// - reserved status bits read one, ignore writes
// - status load 2 cycles, 2n repeated, plus waits
// - factor load fills multiplicand_register, no flags change
// - factor load 1 cycle, plus d, plus p, one more if both external or same block
// - indirect forms pass update code; all but status load take the next selector
// - page pointer gets nine low bits or immediate
// - factor accumulate adds shifted product, sets carry
`ifndef LOAD_UNIT_MAP_VH
`define LOAD_UNIT_MAP_VH

// upper opcode bytes
`define OP_LOAD_PAGE 8'h0D
`define OP_LOAD_PROD_HIGH 8'h75
`define OP_LOAD_STATUS_0 8'h0E
`define OP_LOAD_STATUS_1 8'h0F
`define OP_LOAD_FACTOR 8'h73
`define OP_LOAD_FACTOR_ACC 8'h6A
// short immediate page load keeps only seven opcode bits
`define OP_LOAD_PAGE_IMM 7'h5E

// instruction field positions
`define F_INDIRECT 7
`define F_STATUS_SEL 8
`define F_NEXT_EN 3
`define F_NEXT_HI 2
`define F_OFFSET_HI 6
`define F_UPD_HI 6
`define F_UPD_LO 4

// status word field positions
`define SW_PTR_HI 15
`define SW_PTR_LO 13
`define SW0_OV 12
`define SW0_OVM 11
`define SW_DP_HI 8
`define SW1_CNF 12
`define SW1_TC 11
`define SW1_SXM 10
`define SW1_C 9
`define SW1_XF 4
`define SW1_PM_HI 1

// reset levels of the status bits that wake up set
`define RST_IRQ_MASK 1'b1
`define RST_SIGN_EXT 1'b1
`define RST_EXT_FLAG 1'b1

// operation classes
`define CL_NONE 3'h0
`define CL_PAGE 3'h1
`define CL_PAGE_IMM 3'h2
`define CL_PROD_HIGH 3'h3
`define CL_STATUS 3'h4
`define CL_FACTOR 3'h5
`define CL_FACTOR_ACC 3'h6

// base cycle figures per iteration
`define CYC_ONE 14'h0001
`define CYC_TWO 14'h0002

// reserved bits forced to one in each status word
`define ST0_RSVD 16'h0400
`define ST1_RSVD 16'h01EC

// product shift modes
`define PM_NONE 2'h0
`define PM_LEFT1 2'h1
`define PM_LEFT4 2'h2

// saturation limits
`define ACC_MAX_POS 32'h7FFFFFFF
`define ACC_MAX_NEG 32'h80000000

`endif

// *** cycle_timer.v ***
`timescale 1ns/1ps
// counts down an instruction's cycle budget and flags its last cycle
module cycle_timer (
  input wire ref_clk, // core clock
  input wire reset_n, // async reset, active low
  input wire start, // load a new budget
  input wire [13:0] budget, // total cycles, at least one
  output reg busy, // budget running
  output wire expire // last cycle of the budget
);
  reg [13:0] remain; // cycles left including this one

  assign expire = busy && (remain == `CYC_ONE);

  // budget counter
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      remain <= 14'h0000;
      busy <= 1'b0;
    end else if (start) begin
      remain <= budget;
      busy <= 1'b1;
    end else if (expire) begin
      busy <= 1'b0;
      remain <= 14'h0000;
    end else if (busy) begin
      // plain down count, no wrap since expire stops it at one
      remain <= remain - `CYC_ONE;
    end
  end
endmodule

// *** dsp_load_instruction_unit_properties.sv ***
`timescale 1ns/1ps
// port-level checks on the load unit
module load_unit_checker (
  input wire ref_clk, // core clock
  input wire reset_n, // reset, active low
  input wire instr_valid, // word offered
  input wire [15:0] instr_word, // offered word
  input wire instr_ready, // unit idle
  input wire [7:0] repeat_n, // repeat count
  input wire operand_external, // operand off chip
  input wire code_external, // code off chip
  input wire same_single_port_ram_block, // shared block
  input wire [15:0] mem_addr, // data address
  input wire mem_rd, // read strobe
  input wire [15:0] aux_reg_value, // pointer contents
  input wire aux_update_strobe, // indirect access
  input wire irq_mask_write, // mask write
  input wire instr_done, // done pulse
  input wire illegal_op, // refusal pulse
  input wire [15:0] status_word_zero, // status zero
  input wire [15:0] status_word_one, // status one
  input wire [31:0] product_register // product
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);
  // a taken word, and one with no repeat and no penalty
  wire take = instr_valid & instr_ready;
  wire quiet = (repeat_n == 8'h00) & !operand_external & !code_external & !same_single_port_ram_block;
  wire [7:0] op = instr_word[15:8];
  a_zero_reserved: assert property (status_word_zero[10] == 1'b1)
    else $error("status zero reserved bit low");
  a_one_reserved: assert property (&status_word_one[8:5] && &status_word_one[3:2])
    else $error("status one reserved bits low");
  a_mask_kept: assert property (!irq_mask_write |=> $stable(status_word_zero[9]))
    else $error("mask changed without its write");
  a_direct_page: assert property (mem_rd && !aux_update_strobe |->
    mem_addr[15:7] == status_word_zero[8:0]) else $error("direct address not paged");
  a_indirect_addr: assert property (aux_update_strobe |-> mem_rd && mem_addr == aux_reg_value)
    else $error("indirect address wrong");
  a_factor_time: assert property (take && quiet && op == 8'h73 |=> !instr_done ##1 instr_done)
    else $error("factor load not one cycle");
  a_status_time: assert property (take && quiet && op[7:1] == 7'h07 |=>
    (!instr_done)[*2] ##1 instr_done) else $error("status load not two cycles");
  a_prod_low_keep: assert property (take && op == 8'h75 |-> ##2 $stable(product_register[15:0]))
    else $error("product low half written");
  a_illegal_word: assert property (take && op == 8'hFF |=> illegal_op && instr_ready)
    else $error("foreign word not refused");
  c_factor: cover property (take && quiet && op == 8'h73);
  c_status_one: cover property (take && op == 8'h0F);
  c_refused: cover property (illegal_op);
endmodule
bind dsp_load_instruction_unit load_unit_checker i_load_unit_checker (.ref_clk, .reset_n,
  .instr_valid, .instr_word, .instr_ready, .repeat_n, .operand_external, .code_external,
  .same_single_port_ram_block, .mem_addr, .mem_rd, .aux_reg_value, .aux_update_strobe, .irq_mask_write,
  .instr_done, .illegal_op, .status_word_zero, .status_word_one, .product_register);

// *** dsp_load_instruction_unit_bench.sv ***
`timescale 1ns/1ps
// offers one instruction at a time and checks timing and results
module dsp_load_instruction_unit_bench;
  reg ref_clk = 1'b0; // core clock
  reg reset_n = 1'b0; // reset, active low
  reg instr_valid = 1'b0; // word offered
  reg [15:0] instr_word = 16'h0000; // word
  reg [7:0] repeat_n = 8'h00; // repeat count
  reg operand_external = 1'b0; // operand off chip
  reg code_external = 1'b0; // code off chip
  reg same_single_port_ram_block = 1'b0; // shared block
  reg [3:0] data_wait = 4'h0; // operand waits
  reg [3:0] code_wait = 4'h0; // code waits
  reg [15:0] mem_rdata = 16'h0000; // memory word
  reg [15:0] aux_reg_value = 16'h0000; // pointer contents
  reg irq_mask_write = 1'b0; // mask write
  reg irq_mask_value = 1'b0; // mask value
  wire instr_ready, mem_rd, aux_update_strobe, instr_done, illegal_op;
  wire [15:0] mem_addr, status_word_zero, status_word_one, multiplicand_register;
  wire [2:0] aux_update_code;
  wire [31:0] product_register, accumulator;
  reg [15:0] seen_addr; // last address read
  reg [3:0] seen_upd; // last indirect strobe and code
  integer failures = 0; // mismatches
  integer n_tests = 0; // comparisons
  always #2.5 ref_clk = ~ref_clk;
  dsp_load_instruction_unit i_dsp_load_instruction_unit (.ref_clk, .reset_n, .instr_valid,
    .instr_word, .instr_ready, .repeat_n, .operand_external, .code_external, .same_single_port_ram_block,
    .data_wait, .code_wait, .mem_addr, .mem_rd, .mem_rdata, .aux_reg_value, .aux_update_strobe,
    .aux_update_code, .irq_mask_write, .irq_mask_value, .instr_done, .illegal_op,
    .status_word_zero, .status_word_one, .product_register, .multiplicand_register,
    .accumulator);
  // one comparison, reported at once on mismatch
  task check(input ok, input [8*16-1:0] what);
    begin
      n_tests = n_tests + 1;
      if (ok !== 1'b1) begin
        failures = failures + 1;
        $display("[FAIL] %0t %0s", $time, what);
      end
    end
  endtask
  // offer a word, then count cycles until done; ex is {same block, code ext, operand ext}
  task exec(input [15:0] w, input [7:0] n, input [2:0] ex, input [7:0] dp, input [15:0] dat,
      input integer cyc);
    integer k;
    begin
      @(negedge ref_clk);
      instr_word = w;
      repeat_n = n;
      {same_single_port_ram_block, code_external, operand_external} = ex;
      {data_wait, code_wait} = dp;
      mem_rdata = dat;
      instr_valid = 1'b1;
      @(negedge ref_clk);
      instr_valid = 1'b0;
      k = 1;
      // bounded so a missing done cannot hang the run
      while (instr_done !== 1'b1 && k < 80) begin
        if (mem_rd === 1'b1) begin
          seen_addr = mem_addr;
          seen_upd = {aux_update_strobe, aux_update_code};
        end
        @(negedge ref_clk);
        k = k + 1;
      end
      check(k == cyc + 1, "cycle count");
    end
  endtask
  task test_done;
    begin
      $display("comparisons %0d, mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
        $display("Testbench passed");
      else
        $display("Testbench failed");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(negedge ref_clk);
    reset_n = 1'b1;
    check(status_word_zero === 16'h0600, "zero at reset");
    check(status_word_one === 16'h05FC, "one at reset");
    $display("test reset done");
    // clear the mask first so a loaded one would show
    @(negedge ref_clk);
    irq_mask_write = 1'b1;
    @(negedge ref_clk);
    irq_mask_write = 1'b0;
    exec(16'h0E05, 8'h00, 3'b000, 8'h00, 16'hFFFF, 2);
    check(seen_addr === 16'h0005, "direct addr");
    check(status_word_zero === 16'hFDFF, "zero load");
    check(status_word_one === 16'h05FC, "buffer kept");
    exec(16'h0F03, 8'h02, 3'b000, 8'h00, 16'hA000, 4);
    check(seen_addr === 16'hFF83, "paged addr");
    check(status_word_zero === 16'hBDFF, "pointer copy");
    check(status_word_one === 16'hA1EC, "one load");
    aux_reg_value = 16'h1234;
    exec(16'h0E9A, 8'h00, 3'b000, 8'h00, 16'h6000, 2);
    check(seen_addr === 16'h1234 && seen_upd === 4'h9, "indirect");
    check(status_word_zero === 16'h6400, "next ignored");
    check(status_word_one === 16'hA1EC, "buffer kept");
    $display("test status loads done");
    // immediate form takes no same-block penalty
    exec(16'hBD55, 8'h00, 3'b100, 8'h00, 16'h0000, 2);
    check(status_word_zero === 16'h6555, "page imm");
    exec(16'h0D10, 8'h00, 3'b100, 8'h00, 16'hFE03, 3);
    check(seen_addr === 16'hAA90, "page addr");
    check(status_word_zero === 16'h6403, "page direct");
    $display("test page loads done");
    exec(16'h7520, 8'h00, 3'b000, 8'h00, 16'h0012, 1);
    check(product_register === 32'h00120000, "product high");
    exec(16'h6A05, 8'h00, 3'b000, 8'h00, 16'h0062, 1);
    check(multiplicand_register === 16'h0062, "acc factor");
    check(accumulator === 32'h00120000, "acc sum");
    check(status_word_one[9] === 1'b0, "no carry");
    exec(16'h7521, 8'h03, 3'b100, 8'h00, 16'hFFFF, 4);
    exec(16'h6A06, 8'h00, 3'b001, 8'h20, 16'h0063, 3);
    check(accumulator === 32'h00110000, "wrapped sum");
    check(status_word_one[9] === 1'b1, "carry out");
    $display("test product loads done");
    exec(16'h7307, 8'h00, 3'b011, 8'h32, 16'hBEEF, 7);
    check(multiplicand_register === 16'hBEEF, "factor load");
    check(status_word_one === 16'hA3EC, "flags kept");
    exec(16'h7308, 8'h00, 3'b010, 8'h04, 16'h0001, 5);
    // a word outside the group is refused
    @(negedge ref_clk);
    instr_word = 16'hFFFF;
    instr_valid = 1'b1;
    @(negedge ref_clk);
    instr_valid = 1'b0;
    check(illegal_op === 1'b1 && instr_ready === 1'b1, "refused");
    // a quiet indirect factor load with a next pointer
    exec(16'h7389, 8'h00, 3'b000, 8'h00, 16'h1111, 1);
    check(seen_addr === 16'h1234 && seen_upd === 4'h8, "factor indirect");
    check(multiplicand_register === 16'h1111, "factor value");
    check(status_word_zero === 16'h2403, "next pointer");
    $display("test factor loads done");
    // shift mode one, then saturation with overflow mode on
    exec(16'h0F00, 8'h00, 3'b000, 8'h00, 16'h0001, 2);
    check(status_word_one === 16'h01ED && status_word_zero === 16'h0403, "one shift");
    exec(16'h6A00, 8'h00, 3'b000, 8'h00, 16'h0005, 1);
    check(accumulator === 32'h000F0000, "shifted sum");
    exec(16'h0E00, 8'h00, 3'b000, 8'h00, 16'h0800, 2);
    exec(16'h7500, 8'h00, 3'b000, 8'h00, 16'h3FFF, 1);
    exec(16'h6A00, 8'h00, 3'b000, 8'h00, 16'h0007, 1);
    check(accumulator === 32'h7FFFFFFF, "saturated");
    check(status_word_zero === 16'h1C00, "overflow flag");
    $display("test shift modes done");
    test_done;
  end
  // the run needs about a hundred cycles; this cuts a hang
  initial begin
    #20000;
    failures = failures + 1;
    $display("[FAIL] %0t watchdog expired", $time);
    test_done;
  end
endmodule
